// >>> logic/mce_consts.svh
/*
  Constants of the error capture bank: indices, fields, resets.
  Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
*/
// Notes on behaviour
// - Fault address captured whole, read-only.
// - Modify fault captures the entry address, read-only.
// - Fault lock code 000, 001, 011 or 111 in bits 31:29; the code takes any nonzero MM_SOURCE_IN as the lock.
// - Bits 28:26 hold the inverted lock code, kept on clear.
// - Fault type 01, 10, 11 in bits 15:14; lowest code wins.
// - Bit 2 write intent, bit 1 entry reference, bit 0 length.
// - Parity error stores its 32-bit virtual address.
// - Translation status bits 31:29 give the source.
// - Bits 8:4 keep the stage-five command.
// - Bit 3 shows the write latch was valid.
// - Bit 2 tag, bit 1 data parity error.
// - Translation lock set freezes the other fields unless cleared in the same cycle.
// - Translation lock resets to 0, clears on write one.
// - Cache parity error stores the quadword address.
// - Cache address updates only while its lock is clear or cleared in the same cycle.
`ifndef MCE_CONSTS_SVH
`define MCE_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices and address width
// ----------------------------------------------------------------------
`define MCE_IDX_MM_ADDR 10'h0E8
`define MCE_IDX_MM_PTE 10'h0E9
`define MCE_IDX_MM_STS 10'h0EA
`define MCE_IDX_TB_ADDR 10'h0EC
`define MCE_IDX_TB_STS 10'h0ED
`define MCE_IDX_PC_ADDR 10'h0F2
`define MCE_IDX_PC_STS 10'h0F4
`define MCE_IDX_IRQ_STS 10'h100
`define MCE_IDX_IRQ_MASK 10'h101
`define MCE_ADDR_W 12

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MCE_MM_LOCK_LSB 29
`define MCE_MM_SRC_LSB 26
`define MCE_MM_FAULT_LSB 14
`define MCE_TB_SRC_LSB 29
`define MCE_TB_CMD_LSB 4
`define MCE_FAULT_ACV 2'h1
`define MCE_FAULT_TNV 2'h2
`define MCE_FAULT_MODZ 2'h3
`define MCE_QUAD_MASK 32'hFFFF_FFF8
`define MCE_NUM_EVENTS 3

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define MCE_RST_WORD 32'h0000_0000
`define MCE_RESP_OKAY 2'h0
`define MCE_RESP_SLVERR 2'h2

`endif

// >>> logic/mce_pkg.sv
/*
  Types of the error capture bank: state records of the bus slave and
  of the capture logic. Assumes mce_consts.svh is included alongside.
*/
package mce_pkg;

  // Bus slave state
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_held;
    logic w_held;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } mce_bus_t;

  // Captured error state
  typedef struct packed {
    logic [31:0] mm_addr;
    logic [31:0] mm_pte;
    logic [2:0] mm_lock;
    logic [2:0] mm_src;
    logic [1:0] mm_fault;
    logic mm_modify;
    logic mm_table_entry_reference_flag;
    logic mm_len_viol;
    logic [31:0] tb_addr;
    logic [2:0] tb_src;
    logic [4:0] tb_cmd;
    logic tb_wlatch;
    logic tb_tag;
    logic tb_data;
    logic tb_lock;
    logic [31:0] pc_addr;
    logic pc_lock;
    logic [2:0] irq_sts;
    logic [2:0] irq_mask;
    logic irq;
  } mce_cap_t;

endpackage

// >>> logic/mce_axil_slave.sv
/*
  AXI4-Lite slave: address and data in any order, one write
  pulse and one read lookup per transfer.
  Assumes the bank decodes in the same cycle.
*/
`timescale 1ns/100ps
`include "mce_consts.svh"
module mce_axil_slave import mce_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [11:0] awaddr_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [11:0] araddr_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic wr_en_out,
  output logic [11:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_err_in,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_err_in
);
  mce_bus_t s, next_s;

  // Write pulse once both halves are held and no answer is pending
  assign wr_en_out = s.aw_held && s.w_held && !s.bvalid;
  assign wr_addr_out = s.awaddr;
  assign wr_data_out = s.wdata;
  assign wr_strb_out = s.wstrb;

  // Handshakes; ready pulses for one cycle so payload is taken once
  always_comb begin
    next_s = s;
    next_s.awready = awvalid_in && !s.awready && !s.aw_held && !s.bvalid;
    next_s.wready = wvalid_in && !s.wready && !s.w_held && !s.bvalid;
    next_s.arready = arvalid_in && !s.arready && !s.rvalid;
    if (awvalid_in && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = awaddr_in;
    end
    if (wvalid_in && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata = wdata_in;
      next_s.wstrb = wstrb_in;
    end
    if (wr_en_out) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wr_err_in ? `MCE_RESP_SLVERR : `MCE_RESP_OKAY;
    end else if (s.bvalid && bready_in) begin
      next_s.bvalid = 1'b0;
    end
    if (arvalid_in && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_data_in;
      next_s.rresp = rd_err_in ? `MCE_RESP_SLVERR : `MCE_RESP_OKAY;
    end else if (s.rvalid && rready_in) begin
      next_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign awready_out = s.awready;
  assign wready_out = s.wready;
  assign bvalid_out = s.bvalid;
  assign bresp_out = s.bresp;
  assign arready_out = s.arready;
  assign rvalid_out = s.rvalid;
  assign rdata_out = s.rdata;
  assign rresp_out = s.rresp;
endmodule

// >>> logic/mce_top.sv
/*
  Error capture bank of the memory-management and cache unit:
  fault, translation parity and cache parity records,
  plus an interrupt summary.
  Assumes event inputs come from logic on REF_CLK_IN
  and each is a one-cycle pulse
  with its payload valid in
  the same cycle.
*/
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "mce_consts.svh"
module mce_top import mce_pkg::*; (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // AXI4-Lite register bus
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [11:0] S_AXI_AWADDR_IN,
  input wire logic [2:0] S_AXI_AWPROT_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  output logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  input wire logic [11:0] S_AXI_ARADDR_IN,
  input wire logic [2:0] S_AXI_ARPROT_IN,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  // Memory-management fault report
  input wire logic MM_FAULT_IN,
  input wire logic [2:0] MM_SOURCE_IN,
  input wire logic MM_ACCESS_VIOLATION_IN,
  input wire logic MM_TRANSLATION_NOT_VALID_IN,
  input wire logic MM_MODIFY_ZERO_IN,
  input wire logic [31:0] MM_FAULT_ADDRESS_IN,
  input wire logic [31:0] MM_ENTRY_ADDRESS_IN,
  input wire logic MM_WRITE_INTENT_IN,
  input wire logic MM_TABLE_ENTRY_REFERENCE_IN,
  input wire logic MM_LENGTH_VIOLATION_IN,
  // Translation buffer parity report
  input wire logic TB_PARITY_ERROR_IN,
  input wire logic [2:0] TB_SOURCE_IN,
  input wire logic [4:0] TB_COMMAND_IN,
  input wire logic TB_WRITE_LATCH_VALID_IN,
  input wire logic TB_TAG_PARITY_IN,
  input wire logic TB_DATA_PARITY_IN,
  input wire logic [31:0] TB_VIRTUAL_ADDRESS_IN,
  // Primary cache parity report
  input wire logic PC_PARITY_ERROR_IN,
  input wire logic [31:0] PC_PHYSICAL_ADDRESS_IN,
  // Interrupt and lock state
  output logic IRQ_OUT,
  output logic MM_LOCKED_OUT,
  output logic TB_LOCKED_OUT,
  output logic PC_LOCKED_OUT
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  mce_cap_t c, next_c;
  logic wr_en;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] wr_bits;
  logic wr_err;
  logic [31:0] rd_data;
  logic rd_err;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic sel_mm_sts;
  logic sel_tb_sts;
  logic sel_pc_sts;
  logic sel_irq_sts;
  logic sel_irq_mask;
  logic [1:0] mm_type;
  logic mm_capture;
  logic tb_capture;
  logic pc_capture;
  logic [`MCE_NUM_EVENTS-1:0] events;
  logic [`MCE_NUM_EVENTS-1:0] irq_clear;
  logic [`MCE_NUM_EVENTS-1:0] next_irq_sts;
  logic [31:0] mm_sts_word;
  logic [31:0] tb_sts_word;

  // ----------------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------------
  // Protection bits carry no meaning here; every access is honoured
  mce_axil_slave u_bus (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .awvalid_in(S_AXI_AWVALID_IN),
    .awready_out(S_AXI_AWREADY_OUT),
    .awaddr_in(S_AXI_AWADDR_IN),
    .wvalid_in(S_AXI_WVALID_IN),
    .wready_out(S_AXI_WREADY_OUT),
    .wdata_in(S_AXI_WDATA_IN),
    .wstrb_in(S_AXI_WSTRB_IN),
    .bvalid_out(S_AXI_BVALID_OUT),
    .bready_in(S_AXI_BREADY_IN),
    .bresp_out(S_AXI_BRESP_OUT),
    .arvalid_in(S_AXI_ARVALID_IN),
    .arready_out(S_AXI_ARREADY_OUT),
    .araddr_in(S_AXI_ARADDR_IN),
    .rvalid_out(S_AXI_RVALID_OUT),
    .rready_in(S_AXI_RREADY_IN),
    .rdata_out(S_AXI_RDATA_OUT),
    .rresp_out(S_AXI_RRESP_OUT),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_err_in(wr_err),
    .rd_data_in(rd_data),
    .rd_err_in(rd_err)
  );

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  // Byte strobes gate each lane so a partial write clears no status or lock bit extra, though an unstrobed lane 0 zeroes the mask
  assign wr_bits = wr_data & {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                              {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_idx = wr_addr[11:2];

  // Address decode of writable words
  always_comb begin
    sel_mm_sts = 1'b0;
    sel_tb_sts = 1'b0;
    sel_pc_sts = 1'b0;
    sel_irq_sts = 1'b0;
    sel_irq_mask = 1'b0;
    wr_err = 1'b0;
    if (wr_idx == `MCE_IDX_MM_STS) begin
      sel_mm_sts = wr_en;
    end else if (wr_idx == `MCE_IDX_TB_STS) begin
      sel_tb_sts = wr_en;
    end else if (wr_idx == `MCE_IDX_PC_STS) begin
      sel_pc_sts = wr_en;
    end else if (wr_idx == `MCE_IDX_IRQ_STS) begin
      sel_irq_sts = wr_en;
    end else if (wr_idx == `MCE_IDX_IRQ_MASK) begin
      sel_irq_mask = wr_en;
    end else if (wr_idx == `MCE_IDX_MM_ADDR || wr_idx == `MCE_IDX_MM_PTE ||
                 wr_idx == `MCE_IDX_TB_ADDR || wr_idx == `MCE_IDX_PC_ADDR) begin
      // Read-only words take the write silently
      wr_err = 1'b0;
    end else begin
      wr_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Fault classification
  // ----------------------------------------------------------------------
  // Access violation outranks not-valid, which outranks modify
  always_comb begin
    if (MM_ACCESS_VIOLATION_IN) begin
      mm_type = `MCE_FAULT_ACV;
    end else if (MM_TRANSLATION_NOT_VALID_IN) begin
      mm_type = `MCE_FAULT_TNV;
    end else begin
      mm_type = `MCE_FAULT_MODZ;
    end
  end

  // Capture gates; a clear in the same cycle reopens the gate so the
  // arriving error is kept instead of lost
  assign mm_capture = MM_FAULT_IN && (MM_SOURCE_IN != 3'h0) &&
                      ((c.mm_lock == 3'h0) ||
                       (sel_mm_sts && wr_bits[31:29] == c.mm_lock));
  assign tb_capture = TB_PARITY_ERROR_IN &&
                      (!c.tb_lock || (sel_tb_sts && wr_bits[0]));
  assign pc_capture = PC_PARITY_ERROR_IN &&
                      (!c.pc_lock || (sel_pc_sts && wr_bits[0]));

  // ----------------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------------
  assign events = {pc_capture, tb_capture, mm_capture};
  assign irq_clear = sel_irq_sts ? wr_bits[`MCE_NUM_EVENTS-1:0] : '0;

  // One sticky bit per event; a new event beats a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < `MCE_NUM_EVENTS; gi = gi + 1) begin : g_irq
      assign next_irq_sts[gi] = events[gi] | (c.irq_sts[gi] & ~irq_clear[gi]);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_c = c;
    // Fault lock: software writes the current code back to release it;
    // the inverted source copy is left alone
    if (sel_mm_sts && wr_bits[31:29] == c.mm_lock) begin
      next_c.mm_lock = 3'h0;
    end
    if (mm_capture) begin
      next_c.mm_addr = MM_FAULT_ADDRESS_IN;
      next_c.mm_lock = MM_SOURCE_IN;
      next_c.mm_src = ~MM_SOURCE_IN;
      next_c.mm_fault = mm_type;
      next_c.mm_modify = MM_WRITE_INTENT_IN;
      next_c.mm_table_entry_reference_flag = MM_TABLE_ENTRY_REFERENCE_IN &&
                          (mm_type != `MCE_FAULT_MODZ);
      next_c.mm_len_viol = MM_LENGTH_VIOLATION_IN &&
                           (mm_type == `MCE_FAULT_ACV);
      if (mm_type == `MCE_FAULT_MODZ) begin
        next_c.mm_pte = MM_ENTRY_ADDRESS_IN;
      end
    end
    // Translation lock: write one to clear
    if (sel_tb_sts && wr_bits[0]) begin
      next_c.tb_lock = 1'b0;
    end
    // All translation fields load with the lock in one edge
    if (tb_capture) begin
      next_c.tb_addr = TB_VIRTUAL_ADDRESS_IN;
      next_c.tb_src = TB_SOURCE_IN;
      next_c.tb_cmd = TB_COMMAND_IN;
      next_c.tb_wlatch = TB_WRITE_LATCH_VALID_IN;
      next_c.tb_tag = TB_TAG_PARITY_IN;
      next_c.tb_data = TB_DATA_PARITY_IN;
      next_c.tb_lock = 1'b1;
    end
    // Cache lock: write one to clear, set by a captured error
    if (sel_pc_sts && wr_bits[0]) begin
      next_c.pc_lock = 1'b0;
    end
    if (pc_capture) begin
      next_c.pc_addr = PC_PHYSICAL_ADDRESS_IN & `MCE_QUAD_MASK;
      next_c.pc_lock = 1'b1;
    end
    // Interrupt registers
    next_c.irq_sts = next_irq_sts;
    if (sel_irq_mask) begin
      next_c.irq_mask = wr_bits[`MCE_NUM_EVENTS-1:0];
    end
    // Registered so the output never glitches on decode
    next_c.irq = |(next_irq_sts & next_c.irq_mask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset clears every field, locks and length flag included
  always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  // ----------------------------------------------------------------------
  // Read assembly
  // ----------------------------------------------------------------------
  // Status words; unlisted bits read as zero
  always_comb begin
    mm_sts_word = `MCE_RST_WORD;
    mm_sts_word[31:29] = c.mm_lock;
    mm_sts_word[28:26] = c.mm_src;
    mm_sts_word[15:14] = c.mm_fault;
    mm_sts_word[2] = c.mm_modify;
    mm_sts_word[1] = c.mm_table_entry_reference_flag;
    mm_sts_word[0] = c.mm_len_viol;
    tb_sts_word = `MCE_RST_WORD;
    tb_sts_word[31:29] = c.tb_src;
    tb_sts_word[8:4] = c.tb_cmd;
    tb_sts_word[3] = c.tb_wlatch;
    tb_sts_word[2] = c.tb_tag;
    tb_sts_word[1] = c.tb_data;
    tb_sts_word[0] = c.tb_lock;
  end

  assign rd_idx = S_AXI_ARADDR_IN[11:2];

  // Read mux; reads have no side effects
  always_comb begin
    rd_data = `MCE_RST_WORD;
    rd_err = 1'b0;
    if (rd_idx == `MCE_IDX_MM_ADDR) begin
      rd_data = c.mm_addr;
    end else if (rd_idx == `MCE_IDX_MM_PTE) begin
      rd_data = c.mm_pte;
    end else if (rd_idx == `MCE_IDX_MM_STS) begin
      rd_data = mm_sts_word;
    end else if (rd_idx == `MCE_IDX_TB_ADDR) begin
      rd_data = c.tb_addr;
    end else if (rd_idx == `MCE_IDX_TB_STS) begin
      rd_data = tb_sts_word;
    end else if (rd_idx == `MCE_IDX_PC_ADDR) begin
      rd_data = c.pc_addr;
    end else if (rd_idx == `MCE_IDX_PC_STS) begin
      rd_data = {31'h0000_0000, c.pc_lock};
    end else if (rd_idx == `MCE_IDX_IRQ_STS) begin
      rd_data = {29'h0000_0000, c.irq_sts};
    end else if (rd_idx == `MCE_IDX_IRQ_MASK) begin
      rd_data = {29'h0000_0000, c.irq_mask};
    end else begin
      rd_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs straight from flip-flops, except MM_LOCKED_OUT, an OR of the lock code
  // ----------------------------------------------------------------------
  assign IRQ_OUT = c.irq;
  assign MM_LOCKED_OUT = |c.mm_lock;
  assign TB_LOCKED_OUT = c.tb_lock;
  assign PC_LOCKED_OUT = c.pc_lock;

endmodule

// >>> tb/mce_top_properties.sv
/*
  Checker for mce_top: locks, captures, interrupt, bus holds.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module mce_top_checker (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic MM_FAULT_IN,
  input wire logic [2:0] MM_SOURCE_IN,
  input wire logic TB_PARITY_ERROR_IN,
  input wire logic PC_PARITY_ERROR_IN,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_ARVALID_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic IRQ_OUT,
  input wire logic MM_LOCKED_OUT,
  input wire logic TB_LOCKED_OUT,
  input wire logic PC_LOCKED_OUT
);
  // ------------------------------------------------------------------
  // Capture and lock relations
  // ------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Set wins over a same-cycle clear, so every taken event leaves a lock
  AST_MM_LOCK_SET: assert property (MM_FAULT_IN && MM_SOURCE_IN != 3'h0 |=> MM_LOCKED_OUT)
    else $error("fault lock not set");
  AST_TB_LOCK_SET: assert property (TB_PARITY_ERROR_IN |=> TB_LOCKED_OUT)
    else $error("translation lock not set");
  AST_PC_LOCK_SET: assert property (PC_PARITY_ERROR_IN |=> PC_LOCKED_OUT)
    else $error("cache lock not set");
  // Locks only drop through a register write, seen with its response
  AST_MM_RELEASE: assert property ($fell(MM_LOCKED_OUT) |-> $rose(S_AXI_BVALID_OUT))
    else $error("fault lock dropped without write");
  AST_TB_RELEASE: assert property ($fell(TB_LOCKED_OUT) |-> $rose(S_AXI_BVALID_OUT))
    else $error("translation lock dropped without write");
  // Interrupt moves only on a capture or a register write
  AST_IRQ_RISE: assert property ($rose(IRQ_OUT) |-> $rose(S_AXI_BVALID_OUT) ||
    $past(MM_FAULT_IN) || $past(TB_PARITY_ERROR_IN) || $past(PC_PARITY_ERROR_IN))
    else $error("interrupt rose without cause");
  AST_IRQ_FALL: assert property ($fell(IRQ_OUT) |-> $rose(S_AXI_BVALID_OUT))
    else $error("interrupt fell without write");
  // ------------------------------------------------------------------
  // Bus answers
  // ------------------------------------------------------------------
  AST_B_HOLD: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
    S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
    else $error("write response not held");
  AST_R_HOLD: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
    S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("read data not held");
  AST_R_ANSWER: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
    else $error("read answer late");
endmodule

bind mce_top mce_top_checker chk (.*);

// >>> tb/testbench.sv
/*
  Bench for mce_top: bus reads, captures, locks, interrupt.
  Assumes the checker is bound separately.
*/
`timescale 1ns/100ps
`include "mce_consts.svh"
module testbench;
  // ------------------------------------------------------------------
  // Signals and tables
  // ------------------------------------------------------------------
  logic REF_CLK_IN, RST_N_IN, S_AXI_AWVALID_IN, S_AXI_AWREADY_OUT, S_AXI_WVALID_IN;
  logic S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_BREADY_IN, S_AXI_ARVALID_IN;
  logic S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT, S_AXI_RREADY_IN, IRQ_OUT, MM_LOCKED_OUT;
  logic TB_LOCKED_OUT, PC_LOCKED_OUT, MM_FAULT_IN, MM_ACCESS_VIOLATION_IN;
  logic MM_TRANSLATION_NOT_VALID_IN, MM_MODIFY_ZERO_IN, MM_WRITE_INTENT_IN;
  logic MM_TABLE_ENTRY_REFERENCE_IN, MM_LENGTH_VIOLATION_IN, TB_PARITY_ERROR_IN;
  logic TB_WRITE_LATCH_VALID_IN, TB_TAG_PARITY_IN, TB_DATA_PARITY_IN, PC_PARITY_ERROR_IN;
  logic [11:0] S_AXI_AWADDR_IN, S_AXI_ARADDR_IN;
  logic [2:0] S_AXI_AWPROT_IN, S_AXI_ARPROT_IN, MM_SOURCE_IN, TB_SOURCE_IN;
  logic [31:0] S_AXI_WDATA_IN, S_AXI_RDATA_OUT, MM_FAULT_ADDRESS_IN, MM_ENTRY_ADDRESS_IN;
  logic [31:0] TB_VIRTUAL_ADDRESS_IN, PC_PHYSICAL_ADDRESS_IN, e, d;
  logic [3:0] S_AXI_WSTRB_IN;
  logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, r;
  logic [4:0] TB_COMMAND_IN;
  int err_total = 0;
  int tests_run = 0;
  localparam a_ma = {`MCE_IDX_MM_ADDR, 2'b00};
  localparam a_mp = {`MCE_IDX_MM_PTE, 2'b00};
  localparam a_ms = {`MCE_IDX_MM_STS, 2'b00};
  localparam a_ta = {`MCE_IDX_TB_ADDR, 2'b00};
  localparam a_ts = {`MCE_IDX_TB_STS, 2'b00};
  localparam a_pa = {`MCE_IDX_PC_ADDR, 2'b00};
  localparam a_ps = {`MCE_IDX_PC_STS, 2'b00};
  localparam a_is = {`MCE_IDX_IRQ_STS, 2'b00};
  localparam a_im = {`MCE_IDX_IRQ_MASK, 2'b00};
  // Fault kinds {access, not valid, modify}, expected type, lock code
  logic [2:0] mk[4] = '{3'h7, 3'h3, 3'h1, 3'h0};
  logic [1:0] mt[4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  logic [2:0] mc[4] = '{3'h1, 3'h3, 3'h7, 3'h7};
  // Parity rows: source, command, {latch, tag, data}, address
  typedef struct {logic [2:0] s; logic [4:0] c; logic [2:0] f; logic [31:0] v;} mce_row_t;
  mce_row_t rows[4] = '{'{3'h7, 5'h1F, 3'h4, 32'hFFFF_FFFC}, '{3'h6, 5'h00, 3'h2, 32'h4},
    '{3'h4, 5'h15, 3'h1, 32'h8000_0000}, '{3'h0, 5'h0A, 3'h7, 32'h1234_5678}};

  mce_top uut (.*);

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic end_of_test;
    $display("TB: errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 40) begin
      $display("MISMATCH %0t bus timeout", $time);
      err_total++;
      end_of_test;
    end
  endtask
  // Write: both halves offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge REF_CLK_IN);
    S_AXI_AWADDR_IN <= a;
    S_AXI_WDATA_IN <= v;
    S_AXI_AWVALID_IN <= 1'b1;
    S_AXI_WVALID_IN <= 1'b1;
    S_AXI_BREADY_IN <= 1'b1;
    do begin
      @(posedge REF_CLK_IN);
      n++;
      if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 1'b0;
      if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 1'b0;
    end while (!S_AXI_BVALID_OUT && n < 40);
    rs = S_AXI_BRESP_OUT;
    S_AXI_BREADY_IN <= 1'b0;
    guard(n);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge REF_CLK_IN);
    S_AXI_ARADDR_IN <= a;
    S_AXI_ARVALID_IN <= 1'b1;
    S_AXI_RREADY_IN <= 1'b1;
    do begin
      @(posedge REF_CLK_IN);
      n++;
      if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 1'b0;
    end while (!S_AXI_RVALID_OUT && n < 40);
    v = S_AXI_RDATA_OUT;
    rs = S_AXI_RRESP_OUT;
    S_AXI_RREADY_IN <= 1'b0;
    guard(n);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk(v, x);
    chk(32'(rs), 32'(`MCE_RESP_OKAY));
  endtask
  // Event pulses; address payload scrambled after
  task automatic mm_ev(input logic [2:0] c, input logic [2:0] k, input logic [31:0] a);
    @(posedge REF_CLK_IN);
    MM_SOURCE_IN <= c;
    {MM_ACCESS_VIOLATION_IN, MM_TRANSLATION_NOT_VALID_IN, MM_MODIFY_ZERO_IN} <= k;
    {MM_WRITE_INTENT_IN, MM_TABLE_ENTRY_REFERENCE_IN, MM_LENGTH_VIOLATION_IN} <= {k[0], 2'h3};
    MM_FAULT_ADDRESS_IN <= a;
    MM_ENTRY_ADDRESS_IN <= ~a;
    MM_FAULT_IN <= 1'b1;
    @(posedge REF_CLK_IN);
    MM_FAULT_IN <= 1'b0;
    MM_FAULT_ADDRESS_IN <= a ^ 32'h5555_5555;
    MM_ENTRY_ADDRESS_IN <= a;
  endtask
  task automatic tb_ev(input mce_row_t w);
    @(posedge REF_CLK_IN);
    {TB_SOURCE_IN, TB_COMMAND_IN} <= {w.s, w.c};
    {TB_WRITE_LATCH_VALID_IN, TB_TAG_PARITY_IN, TB_DATA_PARITY_IN} <= w.f;
    TB_VIRTUAL_ADDRESS_IN <= w.v;
    TB_PARITY_ERROR_IN <= 1'b1;
    @(posedge REF_CLK_IN);
    TB_PARITY_ERROR_IN <= 1'b0;
    TB_VIRTUAL_ADDRESS_IN <= ~w.v;
  endtask
  task automatic pc_ev(input logic [31:0] a);
    @(posedge REF_CLK_IN);
    PC_PHYSICAL_ADDRESS_IN <= a;
    PC_PARITY_ERROR_IN <= 1'b1;
    @(posedge REF_CLK_IN);
    PC_PARITY_ERROR_IN <= 1'b0;
    PC_PHYSICAL_ADDRESS_IN <= ~a;
  endtask

  // ------------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------------
  initial begin
    REF_CLK_IN = 1'b0;
    forever #25 REF_CLK_IN = ~REF_CLK_IN;
  end
  initial begin
    {RST_N_IN, S_AXI_AWVALID_IN, S_AXI_AWADDR_IN, S_AXI_AWPROT_IN, S_AXI_WVALID_IN,
      S_AXI_WDATA_IN, S_AXI_BREADY_IN, S_AXI_ARVALID_IN, S_AXI_ARADDR_IN, S_AXI_ARPROT_IN,
      S_AXI_RREADY_IN, MM_FAULT_IN, MM_SOURCE_IN, MM_ACCESS_VIOLATION_IN,
      MM_TRANSLATION_NOT_VALID_IN, MM_MODIFY_ZERO_IN, MM_FAULT_ADDRESS_IN,
      MM_ENTRY_ADDRESS_IN, MM_WRITE_INTENT_IN, MM_TABLE_ENTRY_REFERENCE_IN,
      MM_LENGTH_VIOLATION_IN, TB_PARITY_ERROR_IN, TB_SOURCE_IN, TB_COMMAND_IN,
      TB_WRITE_LATCH_VALID_IN, TB_TAG_PARITY_IN, TB_DATA_PARITY_IN, TB_VIRTUAL_ADDRESS_IN,
      PC_PARITY_ERROR_IN, PC_PHYSICAL_ADDRESS_IN} = '0;
    S_AXI_WSTRB_IN = 4'hF;
    repeat (3) @(posedge REF_CLK_IN);
    RST_N_IN <= 1'b1;
    // Parity rows; a second error must not disturb the lock
    for (int i = 0; i < 4; i++) begin
      e = {rows[i].s, 20'h0, rows[i].c, rows[i].f, 1'b1};
      tb_ev(rows[i]);
      rdc(a_ts, e);
      rdc(a_ta, rows[i].v);
      tb_ev(rows[(i + 1) % 4]);
      rdc(a_ts, e);
      wr(a_ts, 32'h1, r);
      @(negedge REF_CLK_IN);
      chk(32'(TB_LOCKED_OUT), 32'h0);
    end
    // Reset values, read-only write, unmapped read
    rdc(a_ms, 32'h0);
    wr(a_ma, 32'hFFFF_FFFF, r);
    rdc(a_ma, 32'h0);
    rd(12'h000, d, r);
    chk(32'(r), 32'(`MCE_RESP_SLVERR));
    // Fault kinds, lock codes, blocking, release
    for (int i = 0; i < 4; i++) begin
      mm_ev(mc[i], mk[i], 32'hA5A5_0000 + i);
      rdc(a_ms, {mc[i], ~mc[i], 10'h0, mt[i], 11'h0, mk[i][0], mt[i] != 2'h3, mt[i] == 2'h1});
      rdc(a_ma, 32'hA5A5_0000 + i);
      if (mt[i] == 2'h3) rdc(a_mp, 32'h5A5A_FFFF - i);
      mm_ev(3'h7, 3'h4, 32'h0);
      rdc(a_ma, 32'hA5A5_0000 + i);
      wr(a_ms, {mc[i], 29'h0}, r);
      rd(a_ms, d, r);
      chk(32'(d[31:26]), {29'h0, ~mc[i]});
    end
    // Cache capture, lock hold, interrupt mask
    wr(a_is, 32'h7, r);
    wr(a_im, 32'h2, r);
    tb_ev(rows[0]);
    @(negedge REF_CLK_IN);
    chk(32'(IRQ_OUT), 32'h1);
    pc_ev(32'h1234_567F);
    rdc(a_pa, 32'h1234_5678);
    pc_ev(32'hFFFF_FFF0);
    rdc(a_pa, 32'h1234_5678);
    rdc(a_is, 32'h6);
    wr(a_is, 32'h2, r);
    wr(a_ps, 32'h1, r);
    @(negedge REF_CLK_IN);
    chk({30'h0, IRQ_OUT, PC_LOCKED_OUT}, 32'h0);
    end_of_test;
  end
endmodule
